// ===== pkg/wake_sleep_pkg.sv
// Constants, memory map and state type of the wake and sleep sequencer.
package wake_sleep_pkg;

  // ****************************************************************
  // Core clock and derived times
  // ****************************************************************
  localparam int CLK_MHZ      = 50;
  localparam int WAKE_DLY_NS  = 20000;
  localparam int WAKE_CYC     = (WAKE_DLY_NS * CLK_MHZ + 999) / 1000;
  localparam int SLP_WAIT_NS  = 4000;
  localparam int SLP_WAIT_CYC = (SLP_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int SRST_MAX_NS  = 30000;
  localparam int SRST_MAX_CYC = SRST_MAX_NS * CLK_MHZ / 1000;
  localparam int MEMW_TYP_US  = 1800;
  localparam int MEMW_CYC     = MEMW_TYP_US * CLK_MHZ;
  // Nominal one second, the middle of the 0.9 s to 1.1 s window.
  localparam int AUTO_SLEEP_ENABLE_MS      = 1000;
  localparam int AUTO_SLEEP_ENABLE_CYC     = AUTO_SLEEP_ENABLE_MS * 1000 * CLK_MHZ;
  localparam int TMR_W        = 26;

  // ****************************************************************
  // Bus reference oscillator and bit time
  // ****************************************************************
  localparam int OSC_KHZ       = 532;
  localparam int OSC_DIV       = CLK_MHZ * 1000 / OSC_KHZ;
  localparam int OSC_W         = 7;
  localparam int BT_BASE_TICKS = 23;
  localparam int BRK_NUM       = 1391;
  localparam int BRK_DEN       = 1000;

  // ****************************************************************
  // One-time-programmable memory map and configuration fields
  // ****************************************************************
  localparam int         OTP_BYTES    = 16;
  localparam logic [3:0] CFG_ADDR     = 4'h0;
  localparam logic [3:0] TRIM_ADDR    = 4'h1;
  localparam logic [3:0] SECRET_FIRST = 4'h2;
  localparam logic [3:0] SECRET_LAST  = 4'hD;
  localparam logic [3:0] GP_FIRST     = 4'hE;
  localparam logic [3:0] GP_LAST      = 4'hF;
  localparam int         CFG_SLO_LSB  = 0;
  localparam int         CFG_AUTO_SLEEP_ENABLE_BIT = 2;
  localparam int         CFG_INT_BIT  = 3;
  localparam int         CFG_SPD_LSB  = 4;
  localparam int         CFG_DAB_LSB  = 6;

  typedef enum logic [2:0] {
    ST_SLEEP  = 3'b000,
    ST_RD0    = 3'b001,
    ST_RD1    = 3'b010,
    ST_RD2    = 3'b011,
    ST_BREAK  = 3'b100,
    ST_ACTIVE = 3'b101,
    ST_MEMW   = 3'b110,
    ST_SLPW   = 3'b111
  } seq_state_t;

endpackage : wake_sleep_pkg

// ===== hdl/wake_sleep_sequencer.sv
// Power state and readiness sequencer of the single-wire bus device.
`timescale 1ns/1ps
module wake_sleep_sequencer #(
  parameter int AUTO_SLEEP_CYC = wake_sleep_pkg::AUTO_SLEEP_ENABLE_CYC,
  parameter int MEM_WRITE_CYC  = wake_sleep_pkg::MEMW_CYC
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_bus_in,
  input  wire logic       i_sleep_op,
  input  wire logic       i_mem_write_done,
  input  wire logic       i_challenge_done,
  input  wire logic       i_soft_reset,
  input  wire logic       i_auto_sleep_enable_clear,
  input  wire logic [7:0] i_cfg_data,
  output logic            o_bus_out,
  output logic            o_bus_oe,
  output logic            o_regulator_on,
  output logic            o_logic_rst,
  output logic            o_cfg_rd,
  output logic [3:0]      o_cfg_addr,
  output logic [7:0]      o_cfg_byte,
  output logic [7:0]      o_trim,
  output logic [1:0]      o_dev_addr,
  output logic [1:0]      o_bus_speed,
  output logic            o_auto_sleep_en,
  output logic            o_ready,
  output logic            o_auth_valid
);
  import wake_sleep_pkg::*;

  // ****************************************************************
  // Parameter checks and derived counts
  // ****************************************************************
  if (AUTO_SLEEP_CYC < 2 || AUTO_SLEEP_CYC >= (1 << TMR_W)) begin : g_bad_as
    $error("AUTO_SLEEP_CYC out of range");
  end
  if (MEM_WRITE_CYC < 2 || MEM_WRITE_CYC >= (1 << TMR_W)) begin : g_bad_mw
    $error("MEM_WRITE_CYC out of range");
  end

  localparam int AS_M1 = AUTO_SLEEP_CYC - 1;
  localparam int MW_M1 = MEM_WRITE_CYC - 1;
  localparam int WK_M1 = WAKE_CYC - 1;
  localparam int SL_M1 = SLP_WAIT_CYC - 1;
  localparam int OS_M1 = OSC_DIV - 1;
  localparam logic [TMR_W-1:0] AUTO_SLEEP_ENABLE_LAST = AS_M1[TMR_W-1:0];
  localparam logic [TMR_W-1:0] MEMW_LAST = MW_M1[TMR_W-1:0];
  localparam logic [TMR_W-1:0] WAKE_LAST = WK_M1[TMR_W-1:0];
  localparam logic [TMR_W-1:0] SLPW_LAST = SL_M1[TMR_W-1:0];
  localparam logic [OSC_W-1:0] OSC_LAST  = OS_M1[OSC_W-1:0];
  localparam int A_SLP = SLP_WAIT_CYC;

  seq_state_t       st_q, st_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic [TMR_W-1:0] idle_q, idle_d;
  logic [OSC_W-1:0] osc_q, osc_d;
  logic [7:0]       cfg_q, cfg_d, trim_q, trim_d;
  logic [7:0]       abt_q, abt_d;
  logic [3:0]       addr_q, addr_d;
  logic             reg_q, reg_d, rst_q, rst_d, rd_q, rd_d;
  logic             brk_q, brk_d, rdy_q, rdy_d, auto_sleep_enable_q, auto_sleep_enable_d;
  logic             auth_q, auth_d, abusy_q, abusy_d, bus_prev_q;
  logic             osc_tick, idle_hit;
  logic [7:0]       bt_ticks, brk_ticks;
  int               bt_int;

  // ****************************************************************
  // Reference ticks, bit time and bus silence
  // ****************************************************************
  // reference ticks
  assign osc_tick = (osc_q == OSC_LAST);
  assign idle_hit = (idle_q == AUTO_SLEEP_ENABLE_LAST);

  always_comb begin
    bt_int    = BT_BASE_TICKS << cfg_q[CFG_SPD_LSB +: 2];
    bt_ticks  = bt_int[7:0];
    bt_int    = (bt_int * BRK_NUM) / BRK_DEN;
    brk_ticks = bt_int[7:0];
  end

  always_comb begin
    osc_d = osc_tick ? '0 : osc_q + 1'b1;
    if (st_q != ST_ACTIVE || i_bus_in != bus_prev_q) begin
      idle_d = '0;
    end else if (!idle_hit) begin
      idle_d = idle_q + 1'b1;
    end else begin
      idle_d = idle_q;
    end
    auth_d  = auth_q;
    abusy_d = abusy_q;
    abt_d   = abt_q;
    if (st_q != ST_ACTIVE) begin
      auth_d  = 1'b0;
      abusy_d = 1'b0;
    end else if (i_challenge_done) begin
      auth_d  = 1'b0;
      abusy_d = 1'b1;
      abt_d   = '0;
    end else if (abusy_q && osc_tick) begin
      if (abt_q == bt_ticks) begin
        auth_d  = 1'b1;
        abusy_d = 1'b0;
      end else begin
        abt_d = abt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      osc_q      <= '0;
      idle_q     <= '0;
      auth_q     <= 1'b0;
      abusy_q    <= 1'b0;
      abt_q      <= '0;
      bus_prev_q <= 1'b0;
    end else begin
      osc_q      <= osc_d;
      idle_q     <= idle_d;
      auth_q     <= auth_d;
      abusy_q    <= abusy_d;
      abt_q      <= abt_d;
      bus_prev_q <= i_bus_in;
    end
  end

  // ****************************************************************
  // Power and readiness sequencer
  // ****************************************************************
  always_comb begin
    st_d   = st_q;
    tmr_d  = tmr_q;
    reg_d  = reg_q;
    rst_d  = rst_q;
    rd_d   = 1'b0;
    addr_d = addr_q;
    cfg_d  = cfg_q;
    trim_d = trim_q;
    auto_sleep_enable_d = auto_sleep_enable_q;
    brk_d  = brk_q;
    rdy_d  = rdy_q;
    case (st_q)
      ST_SLEEP: begin
        reg_d = 1'b0;
        rst_d = 1'b1;
        rdy_d = 1'b0;
        brk_d = 1'b0;
        if (i_bus_in) begin
          tmr_d = '0;
        end else if (tmr_q == WAKE_LAST) begin
          st_d   = ST_RD0;
          reg_d  = 1'b1;
          rst_d  = 1'b0;
          rd_d   = 1'b1;
          addr_d = CFG_ADDR;
          tmr_d  = '0;
        end else begin
          tmr_d = tmr_q + 1'b1;
        end
      end
      ST_RD0: begin
        rd_d   = 1'b1;
        addr_d = TRIM_ADDR;
        st_d   = ST_RD1;
      end
      ST_RD1: begin
        cfg_d = i_cfg_data;
        auto_sleep_enable_d = i_cfg_data[CFG_AUTO_SLEEP_ENABLE_BIT];
        st_d   = ST_RD2;
      end
      ST_RD2: begin
        trim_d = i_cfg_data;
        brk_d  = 1'b1;
        tmr_d  = '0;
        st_d   = ST_BREAK;
      end
      ST_BREAK: begin
        if (osc_tick) begin
          if (tmr_q[7:0] == brk_ticks) begin
            brk_d = 1'b0;
            rdy_d = 1'b1;
            tmr_d = '0;
            st_d  = ST_ACTIVE;
          end else begin
            tmr_d = tmr_q + 1'b1;
          end
        end
      end
      // Soft reset outranks sleep, which outranks a write.
      ST_ACTIVE: begin
        if (i_auto_sleep_enable_clear) begin
          auto_sleep_enable_d = 1'b0;
        end
        if (i_soft_reset) begin
          st_d   = ST_RD0;
          rd_d   = 1'b1;
          addr_d = CFG_ADDR;
          rdy_d  = 1'b0;
        end else if (i_sleep_op) begin
          st_d  = ST_SLPW;
          tmr_d = '0;
          rdy_d = 1'b0;
        end else if (auto_sleep_enable_q && idle_hit) begin
          st_d  = ST_SLEEP;
          reg_d = 1'b0;
          rst_d = 1'b1;
          rdy_d = 1'b0;
          tmr_d = '0;
        end else if (i_mem_write_done) begin
          st_d  = ST_MEMW;
          tmr_d = '0;
          rdy_d = 1'b0;
        end
      end
      ST_MEMW: begin
        if (tmr_q == MEMW_LAST) begin
          st_d  = ST_ACTIVE;
          rdy_d = 1'b1;
          tmr_d = '0;
        end else begin
          tmr_d = tmr_q + 1'b1;
        end
      end
      ST_SLPW: begin
        if (tmr_q == SLPW_LAST) begin
          st_d  = ST_SLEEP;
          reg_d = 1'b0;
          rst_d = 1'b1;
          tmr_d = '0;
        end else begin
          tmr_d = tmr_q + 1'b1;
        end
      end
      default: begin
        st_d = ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_q   <= ST_SLEEP;
      tmr_q  <= '0;
      reg_q  <= 1'b0;
      rst_q  <= 1'b1;
      rd_q   <= 1'b0;
      addr_q <= CFG_ADDR;
      cfg_q  <= '0;
      trim_q <= '0;
      auto_sleep_enable_q <= 1'b1;
      brk_q  <= 1'b0;
      rdy_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      reg_q  <= reg_d;
      rst_q  <= rst_d;
      rd_q   <= rd_d;
      addr_q <= addr_d;
      cfg_q  <= cfg_d;
      trim_q <= trim_d;
      auto_sleep_enable_q <= auto_sleep_enable_d;
      brk_q  <= brk_d;
      rdy_q  <= rdy_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // low-only drive
  assign o_bus_out       = 1'b0;
  assign o_bus_oe        = brk_q;
  assign o_regulator_on  = reg_q;
  assign o_logic_rst     = rst_q;
  assign o_cfg_rd        = rd_q;
  assign o_cfg_addr      = addr_q;
  assign o_cfg_byte      = cfg_q;
  assign o_trim          = trim_q;
  assign o_dev_addr      = cfg_q[CFG_DAB_LSB +: 2];
  assign o_bus_speed     = cfg_q[CFG_SPD_LSB +: 2];
  assign o_auto_sleep_en = auto_sleep_enable_q;
  assign o_ready         = rdy_q;
  assign o_auth_valid    = auth_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_boot_asleep: assert property (@(posedge i_core_clk)
    i_sys_rst |=> !o_regulator_on && o_logic_rst && !o_ready)
    else $error("not asleep after reset");
  chk_wake_release: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    st_q == ST_SLEEP && !i_bus_in && tmr_q == WAKE_LAST
    |=> !o_logic_rst && o_regulator_on && o_cfg_rd)
    else $error("reset not released after wake");
  chk_cfg_fetch: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    $rose(o_cfg_rd) |-> o_cfg_addr == CFG_ADDR ##1
    o_cfg_rd && o_cfg_addr == TRIM_ADDR ##2 o_bus_oe)
    else $error("config fetch order wrong");
  chk_ready_break: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    $rose(o_bus_oe) |-> !o_ready && $past(o_cfg_addr) == TRIM_ADDR)
    else $error("break without fetch");
  chk_sleep_hold: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    st_q == ST_ACTIVE && i_sleep_op && !i_soft_reset
    |-> ##A_SLP o_regulator_on ##1 !o_regulator_on)
    else $error("sleep wait wrong");
  chk_idle_bound: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    st_q == ST_ACTIVE && auto_sleep_enable_q && idle_hit && !i_soft_reset
    && !i_sleep_op |=> !o_regulator_on && st_q == ST_SLEEP)
    else $error("auto sleep missed");
  chk_write_busy: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    st_q == ST_MEMW |-> !o_ready && tmr_q <= MEMW_LAST)
    else $error("write busy wrong");
  chk_write_end: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    st_q == ST_MEMW && tmr_q == MEMW_LAST |=> o_ready && st_q == ST_ACTIVE)
    else $error("not ready after write time");
  chk_auth_time: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    $rose(o_auth_valid) |-> $past(abt_q) == $past(bt_ticks))
    else $error("result time wrong");
  chk_soft_reset: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    st_q == ST_ACTIVE && i_soft_reset |-> ##4 $rose(o_bus_oe))
    else $error("soft reset break late");
  chk_break_len: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    $fell(o_bus_oe) |-> $past(tmr_q[7:0]) == $past(brk_ticks) && o_ready)
    else $error("break length wrong");
  chk_auto_sleep_enable_load: assert property (@(posedge i_core_clk)
    disable iff (i_sys_rst)
    st_q == ST_RD1 |=> o_auto_sleep_en == $past(i_cfg_data[CFG_AUTO_SLEEP_ENABLE_BIT]))
    else $error("auto sleep default wrong");

  cov_wake: cover property (@(posedge i_core_clk) $rose(o_ready));
  cov_auto: cover property (@(posedge i_core_clk)
    st_q == ST_ACTIVE && auto_sleep_enable_q && idle_hit);
  cov_sleep: cover property (@(posedge i_core_clk) st_q == ST_SLPW);
  cov_auth: cover property (@(posedge i_core_clk) $rose(o_auth_valid));

endmodule : wake_sleep_sequencer

// ===== testbench/host_model.sv
// Host side model: pulled-up single wire bus and the configuration memory.
`timescale 1ns/1ps
module host_model #(
  parameter logic [7:0] CFG_INIT  = 8'h84,
  parameter logic [7:0] TRIM_INIT = 8'h5A
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_hold_low,
  input  wire logic       i_dev_oe,
  input  wire logic       i_rd,
  input  wire logic [3:0] i_addr,
  output logic            o_bus,
  output logic [7:0]      o_data
);
  logic [7:0] mem [16];

  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 8'(8'hA0 + i);
    end
    mem[0] = CFG_INIT;
    mem[1] = TRIM_INIT;
    o_data = 8'h00;
  end

  assign o_bus = ~(i_hold_low | i_dev_oe);

  // Data is not held between reads, so a late capture shows up as garbage.
  always @(posedge i_core_clk) begin
    o_data <= i_rd ? mem[i_addr] : ~o_data;
  end
endmodule : host_model

// ===== testbench/wake_sleep_sequencer_tb.sv
// Self-checking testbench of the wake and sleep sequencer.
`timescale 1ns/1ps
module wake_sleep_sequencer_tb;
  import wake_sleep_pkg::*;
  localparam int BRK = BT_BASE_TICKS * BRK_NUM / BRK_DEN;
  localparam int TK  = OSC_DIV;
  logic       clk, rst, hold, bus, slp, mw, ch, sr, ac;
  logic       oe, bout, reg_on, lrst, rd, aen, rdy, auth;
  logic [7:0] cfg_d, cfg_b, trim;
  logic [3:0] addr;
  logic [1:0] dadr, spd;
  int         err_total, n_tests, n;

  wake_sleep_sequencer #(.AUTO_SLEEP_CYC(300), .MEM_WRITE_CYC(50)) i_dut (
    .i_core_clk(clk), .i_sys_rst(rst), .i_bus_in(bus),
    .i_sleep_op(slp), .i_mem_write_done(mw), .i_challenge_done(ch),
    .i_soft_reset(sr), .i_auto_sleep_enable_clear(ac), .i_cfg_data(cfg_d),
    .o_bus_out(bout), .o_bus_oe(oe), .o_regulator_on(reg_on),
    .o_logic_rst(lrst), .o_cfg_rd(rd), .o_cfg_addr(addr),
    .o_cfg_byte(cfg_b), .o_trim(trim), .o_dev_addr(dadr),
    .o_bus_speed(spd), .o_auto_sleep_en(aen), .o_ready(rdy),
    .o_auth_valid(auth));

  host_model i_host (.i_core_clk(clk), .i_hold_low(hold), .i_dev_oe(oe),
    .i_rd(rd), .i_addr(addr), .o_bus(bus), .o_data(cfg_d));

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task fail(input logic [31:0] g, input logic [31:0] e);
    err_total++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
  endtask : fail

  task chk_bit(input logic g, input logic e);
    n_tests++;
    if (g !== e) fail(32'(g), 32'(e));
  endtask : chk_bit

  task chk_byte(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) fail(32'(g), 32'(e));
  endtask : chk_byte

  task chk_rng(input int g, input int lo, input int hi);
    n_tests++;
    if (g < lo || g > hi) fail(g, lo);
  endtask : chk_rng

  function automatic logic sel(input int s);
    case (s)
      0: return reg_on;
      1: return oe;
      2: return rdy;
      3: return auth;
      default: return aen;
    endcase
  endfunction : sel

  // A wait that runs out of cycles counts as a mismatch and ends the run.
  task wt(input int s, input logic v, input int mx);
    n = 0;
    while (sel(s) !== v) begin
      if (n >= mx) begin
        fail(32'(sel(s)), 32'(v));
        stop_test();
      end
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wt

  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  task pulse(input int s);
    @(posedge clk);
    case (s)
      0: slp <= 1'b1;
      1: mw <= 1'b1;
      2: ch <= 1'b1;
      3: sr <= 1'b1;
      default: ac <= 1'b1;
    endcase
    @(posedge clk);
    {slp, mw, ch, sr, ac} <= 5'h00;
    #1;
  endtask : pulse

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_idle();
    chk_bit(reg_on, 1'b0);
    chk_bit(lrst, 1'b1);
    chk_bit(aen, 1'b1);
    @(posedge clk);
    hold <= 1'b1;
    cyc(500);
    @(posedge clk);
    hold <= 1'b0;
    cyc(1100);
    chk_bit(reg_on, 1'b0);
    $display("test idle done");
  endtask : t_idle

  task t_wake();
    @(posedge clk);
    hold <= 1'b1;
    cyc(995);
    chk_bit(reg_on, 1'b0);
    wt(0, 1'b1, 10);
    chk_rng(n, 4, 8);
    chk_bit(lrst, 1'b0);
    chk_bit(rd, 1'b1);
    chk_byte({4'h0, addr}, 8'h00);
    @(posedge clk);
    hold <= 1'b0;
    #1;
    chk_byte({4'h0, addr}, 8'h01);
    wt(1, 1'b1, 5);
    chk_bit(bus, 1'b0);
    chk_bit(bout, 1'b0);
    chk_byte(cfg_b, 8'h84);
    chk_byte(trim, 8'h5A);
    chk_byte({4'h0, dadr, spd}, 8'h08);
    wt(1, 1'b0, 4000);
    chk_rng(n, BRK * TK, (BRK + 2) * (TK + 1));
    chk_bit(rdy, 1'b1);
    $display("test wake done");
  endtask : t_wake

  task t_mem();
    pulse(4);
    cyc(2);
    chk_bit(aen, 1'b0);
    pulse(1);
    wt(2, 1'b0, 3);
    wt(2, 1'b1, 60);
    chk_rng(n, 45, 55);
    $display("test memory write done");
  endtask : t_mem

  task t_auth();
    pulse(2);
    chk_bit(auth, 1'b0);
    wt(3, 1'b1, 3000);
    chk_rng(n, BT_BASE_TICKS * TK, (BT_BASE_TICKS + 2) * (TK + 1));
    $display("test challenge done");
  endtask : t_auth

  task soft_reset_time();
    pulse(3);
    wt(2, 1'b0, 3);
    wt(1, 1'b1, SRST_MAX_CYC);
    wt(1, 1'b0, 4000);
    chk_bit(aen, 1'b1);
    chk_bit(rdy, 1'b1);
    $display("test soft reset done");
  endtask : soft_reset_time

  task t_auto();
    cyc(200);
    @(posedge clk);
    hold <= 1'b1;
    @(posedge clk);
    hold <= 1'b0;
    cyc(250);
    chk_bit(reg_on, 1'b1);
    wt(0, 1'b0, 100);
    chk_bit(lrst, 1'b1);
    chk_bit(rdy, 1'b0);
    $display("test auto sleep done");
  endtask : t_auto

  task t_sleep();
    pulse(0);
    wt(2, 1'b0, 3);
    cyc(190);
    chk_bit(reg_on, 1'b1);
    wt(0, 1'b0, 15);
    chk_bit(lrst, 1'b1);
    $display("test sleep opcode done");
  endtask : t_sleep

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    {rst, hold, slp, mw, ch, sr, ac} = 7'h40;
    err_total = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_idle();
    t_wake();
    t_mem();
    t_auth();
    soft_reset_time();
    t_auto();
    t_wake();
    t_sleep();
    stop_test();
  end
endmodule : wake_sleep_sequencer_tb
